// file: rtl/seb_params.svh
`ifndef SEB_PARAMS_SVH
`define SEB_PARAMS_SVH

// Slave address fields
`define SEB_DEV_TYPE        4'ha
`define SEB_DEV_TYPE_MSB    7
`define SEB_DEV_TYPE_LSB    4
`define SEB_SEL_HIGH_BIT    3
`define SEB_SEL_MID_BIT     2
`define SEB_SEL_PAGE_BIT    1
`define SEB_RW_BIT          0
`define SEB_RW_READ         1'b1
`define SEB_UPPER_BLOCK     1'b1

// Byte framing
`define SEB_BYTE_BITS       4'h8
`define SEB_IDLE_BYTE       8'hff

// Storage and buffering
`define SEB_ADDR_W          9
`define SEB_DATA_W          8
`define SEB_MEM_BYTES       512
`define SEB_FIFO_WIDTH      17
`define SEB_FIFO_DEPTH      16

// Internal program cycle
`define SEB_CLK_HZ          10000000
`define SEB_T_WR_MS         10
`define SEB_WR_CYCLES       (`SEB_T_WR_MS * `SEB_CLK_HZ / 1000)
`define SEB_TIMER_W         17

`endif

// file: rtl/seb_pkg.sv
package seb_pkg;

    typedef enum logic [2:0] {
        SEB_ST_IDLE      = 3'h0,
        SEB_ST_RX        = 3'h1,
        SEB_ST_ACK       = 3'h2,
        SEB_ST_TX        = 3'h3,
        SEB_ST_TXACK     = 3'h4,
        SEB_ST_TXGAP     = 3'h5,
        SEB_ST_WAIT_STOP = 3'h6
    } seb_link_st_e;

    typedef enum logic [1:0] {
        SEB_K_DEV  = 2'h0,
        SEB_K_WORD = 2'h1,
        SEB_K_DATA = 2'h2
    } seb_kind_e;

endpackage : seb_pkg

// file: rtl/seb_fifo.sv
`timescale 1ns/10ps
module seb_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_sys_i,
    input  wire logic             srst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o  = store[rd_ptr];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            store[wr_ptr] <= in_data_i;
        end
    end

    // Pointers wrap at DEPTH, which must be a power of two
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

endmodule : seb_fifo

// file: rtl/seb_eeprom_slave.sv
`timescale 1ns/10ps
`include "seb_params.svh"

// Overview of operation
// (RL1) Data changes only while clock low
// (RL2) Falling data, clock high, is start
// (RL3) Rising data, clock high, is stop
// (RL4) Master sends second stop after delay
// (RL5) Device is slave, never drives clock
// (RL6) Upper address nibble must be 1010
// (RL7) Compare two upper selection bits to pins
// (RL8) Lowest selection bit picks page block
// (RL9) Block bit plus byte form address
// (RL10) Last address bit selects read/write
// (RL11) Acknowledge matching address, else stay silent
// (RL12) Acknowledge every written byte when selected
// (RL13) Read: eight bits, then check acknowledge
// (RL14) Word address byte follows slave address
// (RL15) Stop after data byte starts programming
// (RL16) Ignore bus while program cycle runs
// (RL17) Acknowledge low during ninth clock
// (RL18) Protected upper half: data unacknowledged
// (RL19) Synchronise bus lines before edge detection
module seb_eeprom_slave #(
    parameter int WRITE_CYCLES = `SEB_WR_CYCLES
) (
    input  wire logic clk_sys_i,
    input  wire logic srst_i,
    input  wire logic clk_link_i,
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe_o,
    input  wire logic chip_select_pin_mid_i,
    input  wire logic chip_select_pin_high_i,
    input  wire logic write_protect_i,
    output logic      program_busy_o
);
    import seb_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    // Link domain
    logic                   link_rst_m;
    logic                   link_rst;
    logic                   scl_m, scl_s, scl_p;
    logic                   sda_m, sda_s, sda_p;
    logic                   pin_mid_m, pin_mid_s;
    logic                   pin_high_m, pin_high_s;
    logic                   wp_m, wp_s;
    logic                   wr_ack_m, wr_ack_s;
    logic                   rd_ack_m, rd_ack_s;
    seb_link_st_e           state;
    seb_kind_e              kind;
    logic [3:0]             nbit;
    logic [7:0]             shreg;
    logic                   go_tx;
    logic                   page;
    logic [7:0]             word_addr;
    logic                   wr_pending;
    logic [`SEB_ADDR_W-1:0] wr_addr;
    logic [7:0]             wr_data;
    logic                   wr_req_t;
    logic [`SEB_ADDR_W-1:0] rd_addr;
    logic                   rd_req_t;
    logic                   next_sda_oe;

    // Link domain decode
    logic                   scl_rise;
    logic                   scl_fall;
    logic                   start_det;
    logic                   stop_det;
    logic                   link_busy;
    logic                   rd_ready;
    logic                   rx_end;
    logic                   dev_match;
    logic                   data_protect;
    logic                   give_ack;
    logic                   tx_load;
    logic [7:0]             tx_byte;

    // System domain
    logic                   wr_req_m, wr_req_s, wr_req_p;
    logic                   rd_req_m, rd_req_s, rd_req_p;
    logic                   push_valid;
    logic [`SEB_FIFO_WIDTH-1:0] push_data;
    logic                   push_ready;
    logic                   pop_valid;
    logic [`SEB_FIFO_WIDTH-1:0] pop_data;
    logic                   prog_busy;
    logic [`SEB_TIMER_W-1:0] timer;
    logic [`SEB_ADDR_W-1:0] prog_addr;
    logic [7:0]             prog_data;
    logic                   wr_ack_t;
    logic [7:0]             rd_data;
    logic                   rd_ack_t;
    logic [7:0]             mem [`SEB_MEM_BYTES];

    ////////////////////////////////////////////////////////////////////////
    // Link domain synchronisers

    always_ff @(posedge clk_link_i) begin
        link_rst_m <= srst_i;
        link_rst   <= link_rst_m;
    end

    // (RL5) clock only sampled, never driven
    // (RL19) two-stage line sync
    always_ff @(posedge clk_link_i) begin
        scl_m      <= scl_i;
        scl_s      <= scl_m;
        scl_p      <= scl_s;
        sda_m      <= sda_i;
        sda_s      <= sda_m;
        sda_p      <= sda_s;
        pin_mid_m  <= chip_select_pin_mid_i;
        pin_mid_s  <= pin_mid_m;
        pin_high_m <= chip_select_pin_high_i;
        pin_high_s <= pin_high_m;
        wp_m       <= write_protect_i;
        wp_s       <= wp_m;
        wr_ack_m   <= wr_ack_t;
        wr_ack_s   <= wr_ack_m;
        rd_ack_m   <= rd_ack_t;
        rd_ack_s   <= rd_ack_m;
    end

    ////////////////////////////////////////////////////////////////////////
    // Link domain decode

    // (RL1) edges only from stable samples
    assign scl_rise  = scl_s && !scl_p;
    assign scl_fall  = !scl_s && scl_p;
    // (RL2) start detect
    assign start_det = scl_s && scl_p && sda_p && !sda_s;
    // (RL3) stop detect
    assign stop_det  = scl_s && scl_p && !sda_p && sda_s;

    // Busy from launch until the program cycle hands its toggle back
    assign link_busy = wr_req_t ^ wr_ack_s;
    assign rd_ready  = (rd_req_t == rd_ack_s);
    assign rx_end    = (state == SEB_ST_RX) && scl_fall
                       && (nbit == `SEB_BYTE_BITS);

    // (RL6) device type nibble
    // (RL7) upper selection bits against pins
    assign dev_match =
        (shreg[`SEB_DEV_TYPE_MSB:`SEB_DEV_TYPE_LSB] == `SEB_DEV_TYPE)
        && (shreg[`SEB_SEL_HIGH_BIT] == pin_high_s)
        && (shreg[`SEB_SEL_MID_BIT] == pin_mid_s);

    // (RL18) protected upper block
    assign data_protect = wp_s && (page == `SEB_UPPER_BLOCK);

    // (RL11) address acknowledge decision
    // (RL12) every write byte answered, except data bytes to the protected block (RL18)
    always_comb begin
        give_ack = 1'b0;
        unique case (kind)
            SEB_K_DEV: begin
                give_ack = dev_match;
            end
            SEB_K_WORD: begin
                give_ack = 1'b1;
            end
            SEB_K_DATA: begin
                give_ack = !data_protect;
            end
            default: begin
                give_ack = 1'b0;
            end
        endcase
    end

    // A late prefetch sends all ones rather than stalling the clock
    assign tx_byte = rd_ready ? rd_data : `SEB_IDLE_BYTE;
    assign tx_load = scl_fall && (((state == SEB_ST_ACK) && go_tx)
                                  || (state == SEB_ST_TXGAP));

    ////////////////////////////////////////////////////////////////////////
    // Link protocol state machine

    always_ff @(posedge clk_link_i) begin
        if (link_rst) begin
            state <= SEB_ST_IDLE;
            kind  <= SEB_K_DEV;
            nbit  <= 4'h0;
            shreg <= 8'h00;
            go_tx <= 1'b0;
        end else if (stop_det) begin
            // (RL3) stop ends any transaction
            state <= SEB_ST_IDLE;
        end else if (start_det) begin
            // (RL16) requests ignored while busy
            state <= link_busy ? SEB_ST_IDLE : SEB_ST_RX;
            kind  <= SEB_K_DEV;
            nbit  <= 4'h0;
            go_tx <= 1'b0;
        end else begin
            unique case (state)
                SEB_ST_IDLE: begin
                    // (RL2) wait for a start
                    nbit <= 4'h0;
                end
                SEB_ST_RX: begin
                    if (scl_rise) begin
                        shreg <= {shreg[6:0], sda_s};
                        nbit  <= nbit + 4'h1;
                    end
                    if (rx_end) begin
                        nbit  <= 4'h0;
                        state <= give_ack ? SEB_ST_ACK : SEB_ST_WAIT_STOP;
                        // (RL10) direction bit
                        go_tx <= (kind == SEB_K_DEV)
                                 && (shreg[`SEB_RW_BIT] == `SEB_RW_READ);
                        // (RL14) word address follows
                        kind  <= (kind == SEB_K_DEV) ? SEB_K_WORD
                                                     : SEB_K_DATA;
                    end
                end
                SEB_ST_ACK: begin
                    if (scl_fall) begin
                        state <= go_tx ? SEB_ST_TX : SEB_ST_RX;
                        if (go_tx) begin
                            shreg <= tx_byte;
                        end
                    end
                end
                SEB_ST_TX: begin
                    if (scl_rise) begin
                        nbit <= nbit + 4'h1;
                    end
                    if (scl_fall) begin
                        if (nbit == `SEB_BYTE_BITS) begin
                            state <= SEB_ST_TXACK;
                            nbit  <= 4'h0;
                        end else begin
                            shreg <= {shreg[6:0], 1'b0};
                        end
                    end
                end
                SEB_ST_TXACK: begin
                    // (RL13) continue only on master acknowledge
                    if (scl_rise) begin
                        state <= sda_s ? SEB_ST_WAIT_STOP : SEB_ST_TXGAP;
                    end
                end
                SEB_ST_TXGAP: begin
                    if (scl_fall) begin
                        state <= SEB_ST_TX;
                        shreg <= tx_byte;
                    end
                end
                SEB_ST_WAIT_STOP: begin
                    nbit <= 4'h0;
                end
                default: begin
                    state <= SEB_ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data line drive (open drain: only ever pulls low)

    always_comb begin
        next_sda_oe = sda_oe_o;
        if (stop_det || start_det) begin
            next_sda_oe = 1'b0;
        end else if (rx_end) begin
            // (RL17) ninth clock acknowledge
            next_sda_oe = give_ack;
        end else if (scl_fall) begin
            unique case (state)
                SEB_ST_ACK: begin
                    // (RL17) release after ninth clock
                    next_sda_oe = go_tx && !tx_byte[7];
                end
                SEB_ST_TX: begin
                    // (RL13) release for master acknowledge
                    next_sda_oe = (nbit != `SEB_BYTE_BITS) && !shreg[6];
                end
                SEB_ST_TXGAP: begin
                    next_sda_oe = !tx_byte[7];
                end
                default: begin
                    next_sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_link_i) begin
        if (link_rst) begin
            sda_oe_o <= 1'b0;
            sda_o    <= 1'b0;
        end else begin
            sda_oe_o <= next_sda_oe;
            sda_o    <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address pointer and write capture

    always_ff @(posedge clk_link_i) begin
        if (link_rst) begin
            page       <= 1'b0;
            word_addr  <= 8'h00;
            wr_pending <= 1'b0;
            wr_addr    <= '0;
            wr_data    <= 8'h00;
            wr_req_t   <= 1'b0;
            rd_addr    <= '0;
            rd_req_t   <= 1'b0;
        end else if (stop_det) begin
            // (RL15) stop launches the program cycle
            if (wr_pending && !link_busy) begin
                wr_req_t <= !wr_req_t;
            end
            wr_pending <= 1'b0;
        end else if (start_det) begin
            // A repeated start abandons an unfinished write
            wr_pending <= 1'b0;
        end else if (rx_end && give_ack) begin
            unique case (kind)
                SEB_K_DEV: begin
                    // (RL8) page block from lowest select bit
                    page <= shreg[`SEB_SEL_PAGE_BIT];
                    if (shreg[`SEB_RW_BIT] == `SEB_RW_READ) begin
                        // (RL9) block bit joins byte address
                        rd_addr  <= {shreg[`SEB_SEL_PAGE_BIT], word_addr};
                        rd_req_t <= !rd_req_t;
                    end
                end
                SEB_K_WORD: begin
                    // (RL14) word address stored
                    word_addr <= shreg;
                end
                SEB_K_DATA: begin
                    // (RL15) byte held for programming
                    wr_addr    <= {page, word_addr};
                    wr_data    <= shreg;
                    wr_pending <= 1'b1;
                    word_addr  <= word_addr + 8'h01;
                end
                default: begin
                    wr_pending <= 1'b0;
                end
            endcase
        end else if (tx_load) begin
            // Prefetch the next byte while this one shifts out
            word_addr <= word_addr + 8'h01;
            rd_addr   <= {page, word_addr + 8'h01};
            rd_req_t  <= !rd_req_t;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // System domain: request crossings

    // Link-side address and data stay still until the toggle returns
    always_ff @(posedge clk_sys_i) begin
        wr_req_m <= wr_req_t;
        wr_req_s <= wr_req_m;
        rd_req_m <= rd_req_t;
        rd_req_s <= rd_req_m;
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            wr_req_p   <= 1'b0;
            push_valid <= 1'b0;
            push_data  <= '0;
        end else begin
            wr_req_p <= wr_req_s;
            if (wr_req_s != wr_req_p) begin
                push_valid <= 1'b1;
                push_data  <= {wr_addr, wr_data};
            end else if (push_ready) begin
                push_valid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            rd_req_p <= 1'b0;
            rd_ack_t <= 1'b0;
            rd_data  <= 8'h00;
        end else begin
            rd_req_p <= rd_req_s;
            if (rd_req_s != rd_req_p) begin
                rd_data  <= mem[rd_addr];
                rd_ack_t <= !rd_ack_t;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write buffer and program cycle

    seb_fifo #(
        .WIDTH (`SEB_FIFO_WIDTH),
        .DEPTH (`SEB_FIFO_DEPTH)
    ) u_wr_fifo (
        .clk_sys_i   (clk_sys_i),
        .srst_i      (srst_i),
        .in_valid_i  (push_valid),
        .in_ready_o  (push_ready),
        .in_data_i   (push_data),
        .out_valid_o (pop_valid),
        .out_ready_i (!prog_busy),
        .out_data_o  (pop_data)
    );

    // (RL16) busy holds off the link until done
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            prog_busy <= 1'b0;
            timer     <= '0;
            prog_addr <= '0;
            prog_data <= 8'h00;
            wr_ack_t  <= 1'b0;
        end else if (!prog_busy) begin
            if (pop_valid) begin
                prog_busy <= 1'b1;
                timer     <= `SEB_TIMER_W'(WRITE_CYCLES - 1);
                prog_addr <= pop_data[`SEB_FIFO_WIDTH-1:`SEB_DATA_W];
                prog_data <= pop_data[`SEB_DATA_W-1:0];
            end
        end else if (timer == '0) begin
            prog_busy <= 1'b0;
            wr_ack_t  <= !wr_ack_t;
        end else begin
            timer <= timer - 1'b1;
        end
    end

    // Array has no reset: it models nonvolatile contents
    always_ff @(posedge clk_sys_i) begin
        if (prog_busy && (timer == '0)) begin
            mem[prog_addr] <= prog_data;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            program_busy_o <= 1'b0;
        end else begin
            program_busy_o <= prog_busy || push_valid || pop_valid;
        end
    end

endmodule : seb_eeprom_slave

// file: testbench/seb_eeprom_monitor.sv
`timescale 1ns/10ps
module seb_eeprom_monitor #(
    parameter int WRITE_CYCLES = 20
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic clk_link_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic chip_select_pin_mid_i,
    input wire logic chip_select_pin_high_i,
    input wire logic write_protect_i,
    input wire logic program_busy_o
);
    int bc;

    // Busy length, counted so the long program time needs no repetition
    always_ff @(posedge clk_sys_i) begin
        if (srst_i || !program_busy_o) begin
            bc <= 0;
        end else begin
            bc <= bc + 1;
        end
    end
    ////////////////////////////////////////
    sequence s_drive;
        $rose(sda_oe_o);
    endsequence
    property p_od;
        @(posedge clk_link_i) disable iff (srst_i) sda_o == 1'b0;
    endproperty
    a_od: assert property (p_od)
        else $error("data pin driven high");
    property p_move;
        @(posedge clk_link_i) disable iff (srst_i)
        $changed(sda_oe_o) |-> !scl_i;
    endproperty
    a_move: assert property (p_move)
        else $error("data moved with clock high");
    property p_hold;
        @(posedge clk_link_i) disable iff (srst_i)
        sda_oe_o && scl_i |=> sda_oe_o;
    endproperty
    a_hold: assert property (p_hold)
        else $error("drive dropped in clock high");
    property p_release;
        @(posedge clk_link_i) disable iff (srst_i)
        s_drive |-> ##[1:300] !sda_oe_o;
    endproperty
    a_release: assert property (p_release)
        else $error("data line never released");
    property p_quiet;
        @(posedge clk_sys_i) disable iff (srst_i)
        program_busy_o |-> !sda_oe_o;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("bus answered while programming");
    property p_len;
        @(posedge clk_sys_i) disable iff (srst_i)
        $fell(program_busy_o) |->
            bc >= WRITE_CYCLES && bc <= WRITE_CYCLES + 8;
    endproperty
    a_len: assert property (p_len)
        else $error("program time wrong");
    property p_launch;
        @(posedge clk_sys_i) disable iff (srst_i)
        $rose(program_busy_o) |-> scl_i && sda_i;
    endproperty
    a_launch: assert property (p_launch)
        else $error("program began before stop");
    property p_rst;
        @(posedge clk_sys_i) disable iff (srst_i)
        $fell(srst_i) |-> !program_busy_o [*2];
    endproperty
    a_rst: assert property (p_rst)
        else $error("busy out of reset");
endmodule : seb_eeprom_monitor

bind seb_eeprom_slave seb_eeprom_monitor #(
    .WRITE_CYCLES(WRITE_CYCLES)
) i_mon (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .clk_link_i(clk_link_i),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .chip_select_pin_mid_i(chip_select_pin_mid_i),
    .chip_select_pin_high_i(chip_select_pin_high_i),
    .write_protect_i(write_protect_i), .program_busy_o(program_busy_o)
);

// file: testbench/seb_bus_master.sv
`timescale 1ns/10ps
module seb_bus_master #(
    parameter int HALF = 20
) (
    input  wire logic       clk_i,
    input  wire logic       sda_i,
    output logic            scl_o,
    output logic            sda_low_o,
    output logic            res_v_o,
    output logic      [8:0] res_o
);
    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
        res_v_o   = 1'b0;
        res_o     = 9'h000;
    end

    task automatic tick(input int k);
        repeat (k) @(negedge clk_i);
    endtask : tick

    task automatic frame(input logic s, input logic e);
        scl_o     = 1'b0;
        tick(2);
        sda_low_o = s;
        tick(HALF);
        scl_o     = 1'b1;
        tick(HALF);
        sda_low_o = e;
        tick(HALF);
    endtask : frame

    task automatic byte_io(input logic [8:0] tx, input logic rd);
        logic [8:0] r;
        for (int i = 8; i >= 0; i--) begin
            scl_o     = 1'b0;
            tick(2);
            sda_low_o = !tx[i];
            tick(HALF - 2);
            scl_o     = 1'b1;
            tick(HALF / 2);
            r[i]      = sda_i;
            tick(HALF / 2);
        end
        res_o   = rd ? {1'b1, r[8:1]} : {8'h00, !r[0]};
        res_v_o = 1'b1;
        tick(1);
        res_v_o = 1'b0;
    endtask : byte_io
endmodule : seb_bus_master

// file: testbench/tb.sv
`timescale 1ns/10ps
module tb;
    localparam int WC = 800;
    logic        clk_sys_i;
    logic        clk_link_i;
    logic        srst_i;
    logic        wp;
    logic        scl;
    logic        sda;
    logic        sda_o;
    logic        sda_oe;
    logic        m_low;
    logic        busy;
    logic        res_v;
    logic [8:0]  res;
    logic [8:0]  e;
    logic [8:0]  exp_q[$];
    logic [7:0]  mem[512];
    logic [31:0] seed;
    logic [7:0]  bad[3];
    int          fails;
    int          total_checks;
    int          cyc;

    // Open-drain line with pull-up
    assign sda = !m_low && (sda_oe ? sda_o : 1'b1);

    seb_eeprom_slave #(
        .WRITE_CYCLES(WC)
    ) i_dut (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i), .clk_link_i(clk_link_i),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
        .chip_select_pin_mid_i(1'b0), .chip_select_pin_high_i(1'b1),
        .write_protect_i(wp), .program_busy_o(busy)
    );
    seb_bus_master i_master (
        .clk_i(clk_sys_i), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low),
        .res_v_o(res_v), .res_o(res)
    );

    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = !clk_sys_i;
    end
    initial begin
        clk_link_i = 1'b0;
        #23;
        forever #80 clk_link_i = !clk_link_i;
    end
    ////////////////////////////////////////
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd

    task automatic end_of_test();
        $display("Checks %0d errors %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test

    task automatic cmp_ack(input logic x, input logic s);
        total_checks++;
        if (s !== x) begin
            fails++;
            $display("Error ack expected %b seen %b", x, s);
        end
    endtask : cmp_ack

    task automatic cmp_byte(input logic [7:0] x, input logic [7:0] s);
        total_checks++;
        if (s !== x) begin
            fails++;
            $display("Error read byte expected %h seen %h", x, s);
        end
    endtask : cmp_byte

    task automatic tick(input int k);
        repeat (k) @(negedge clk_sys_i);
    endtask : tick

    task automatic st();
        i_master.frame(1'b0, 1'b1);
    endtask : st

    task automatic sp();
        i_master.frame(1'b1, 1'b0);
    endtask : sp

    task automatic wb(input logic [7:0] d, input logic a);
        exp_q.push_back({8'h00, a});
        i_master.byte_io({d, 1'b1}, 1'b0);
    endtask : wb

    task automatic rb(input logic [7:0] d, input logic a);
        exp_q.push_back({1'b1, d});
        i_master.byte_io({8'hff, !a}, 1'b1);
    endtask : rb

    // Byte write, a refused poll while busy, then the second stop
    task automatic bwrite(input logic b, input logic [7:0] w);
        int k;
        k = 0;
        mem[{b, w}] = rnd();
        st();
        wb({6'h2a, b, 1'b0}, 1'b1);
        wb(w, 1'b1);
        wb(mem[{b, w}], 1'b1);
        sp();
        st();
        wb({6'h2a, b, 1'b0}, 1'b0);
        sp();
        while (busy !== 1'b0 && k < 2 * WC) begin
            tick(1);
            k++;
        end
        tick(40);
        sp();
    endtask : bwrite

    always @(posedge clk_sys_i) begin
        if (res_v === 1'b1) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("Error result expected none seen %h", res);
            end else begin
                e = exp_q.pop_front();
                if (e[8]) begin
                    cmp_byte(e[7:0], res[7:0]);
                end else begin
                    cmp_ack(e[0], res[0]);
                end
            end
        end
    end

    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 40000) begin
            fails++;
            end_of_test();
        end
    end

    initial begin
        srst_i       = 1'b1;
        wp           = 1'b0;
        seed         = 32'h0000bd82;
        fails        = 0;
        total_checks = 0;
        cyc          = 0;
        bad          = '{8'hb8, 8'ha0, 8'hac};
        tick(8);
        srst_i = 1'b0;
        tick(10);
        foreach (bad[i]) begin
            st();
            wb(bad[i], 1'b0);
            sp();
        end
        for (int b = 0; b < 2; b++) begin
            for (int j = 0; j < 2; j++) begin
                bwrite(b[0], 8'hff + j[7:0]);
            end
        end
        wp = 1'b1;
        st();
        wb(8'haa, 1'b1);
        wb(8'hff, 1'b1);
        wb(~mem[9'h1ff], 1'b0);
        sp();
        st();
        wb(8'haa, 1'b1);
        sp();
        wp = 1'b0;
        for (int b = 0; b < 2; b++) begin
            st();
            wb({6'h2a, b[0], 1'b0}, 1'b1);
            wb(8'hff, 1'b1);
            st();
            wb({6'h2a, b[0], 1'b1}, 1'b1);
            rb(mem[{b[0], 8'hff}], 1'b1);
            rb(mem[{b[0], 8'h00}], 1'b0);
            sp();
        end
        tick(20);
        if (exp_q.size() != 0) begin
            fails++;
        end
        end_of_test();
    end
endmodule : tb
